// ===== ascp_pkg.sv
// package for the audio serial config / prescaler block
// assumes a 32-bit avalon-mm register bus with byte addresses
package ascp_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h1c;
  localparam logic [7:0]  ADDR_PSC       = 8'h20;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] PSC_RESET      = 32'h0000_0002;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
  // ----------------------------------------------------------------
  // control and prescaler field positions
  // ----------------------------------------------------------------
  localparam int CTL_PERS_BIT  = 11;
  localparam int CTL_EN_BIT    = 10;
  localparam int CTL_ROLE_LO   = 8;
  localparam int CTL_PCM_BIT   = 7;
  localparam int CTL_STD_LO    = 4;
  localparam int CTL_IDLE_CLOCK_POLARITY_BIT  = 3;
  localparam int CTL_DLEN_LO   = 1;
  localparam int CTL_SLOT_WIDTH_SELECT_BIT = 0;
  localparam int PSC_MCKOE_BIT = 9;
  localparam int PSC_ODD_BIT   = 8;
  localparam int PSC_DIV_LO    = 0;
  localparam int DIV_W         = 8;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0fbf;
  localparam logic [31:0] PSC_WR_MASK  = 32'h0000_03ff;
  // bits frozen while audio is enabled: role, pcm, std, idle_clock_polarity, widths
  localparam logic [31:0] CTRL_LOCK_MASK = 32'h0000_03bf;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ROLE_SLV_TX = 2'h0;
  localparam logic [1:0] ROLE_SLV_RX = 2'h1;
  localparam logic [1:0] ROLE_MST_TX = 2'h2;
  localparam logic [1:0] ROLE_MST_RX = 2'h3;
  localparam logic [1:0] DLEN_RSVD   = 2'h3;
  typedef struct packed {
    logic       personality_select;
    logic       audio_enable;
    logic [1:0] audio_role_select;
    logic       pcm_sync_length_select;
    logic [1:0] framing_standard_select;
    logic       idle_clock_polarity;
    logic [1:0] sample_width_select;
    logic       slot_width_select;
  } ascp_cfg_t;
endpackage

// ===== ascp_top.sv
// audio serial mode configuration and bit clock prescaler
// assumes a kernel clock on MCLK, avalon-mm master that holds requests
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// RQ1 - bit 11 of control selects SPI (0) or audio (1) and may change only while both are off.
// RQ2 - bit 10 enables audio operation and is ignored while SPI personality is chosen.
// RQ3 - bits 9:8 choose slave tx, slave rx, master tx, master rx and are frozen while enabled.
// RQ4 - bit 7 chooses short (0) or long (1) PCM sync and matters only for the PCM standard.
// RQ5 - bits 5:4 choose Philips, MSB, LSB or PCM framing and are frozen while enabled.
// RQ6 - bit 3 sets the idle level of the serial bit clock pin.
// RQ7 - bits 2:1 choose 16, 24 or 32 bit samples and the value 11 is reserved.
// RQ8 - bit 0 chooses a 16 or 32 bit slot, which software keeps no narrower than the sample.
// RQ9 - prescaler bit 9 enables the master clock pin and is frozen while enabled.
// RQ10 - the division ratio is twice the 8-bit factor plus the odd bit.
// RQ11 - software never writes a zero factor and changes the prescaler only while disabled.
// RQ12 - prescaler resets to 0x0002 and control resets to zero.
// RQ13 - master roles divide the kernel clock for the bit clock, slave roles use the pin.
module ascp_top (
  input  wire logic                MCLK,
  input  wire logic                SYS_RST,
  input  wire logic [7:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [3:0]          AVS_BYTEENABLE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire logic                SPI_ENABLE,
  input  wire logic                SERIAL_BIT_CLOCK_PIN_IN,
  output logic                     SERIAL_BIT_CLOCK_PIN_OUT,
  output logic                     SERIAL_BIT_CLOCK_PIN_OE_N,
  output logic                     MASTER_CLOCK_PIN,
  output logic                     MASTER_CLOCK_PIN_OE_N,
  output logic                     AUDIO_ACTIVE,
  output logic                     BIT_CLOCK_EDGE,
  output ascp_pkg::ascp_cfg_t      AUDIO_CFG
);
  import ascp_pkg::*;

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] psc_ff, nxt_psc;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ack_ff, nxt_ack;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic        req;
  logic        locked;

  assign req    = (AVS_READ | AVS_WRITE) & ~ack_ff;
  assign locked = ctrl_ff[CTL_PERS_BIT] & ctrl_ff[CTL_EN_BIT];
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wr_val = AVS_WRITEDATA & be_mask;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_psc   = psc_ff;
    nxt_rdata = rdata_ff;
    nxt_ack   = req;
    if (req && AVS_WRITE) begin
      if (AVS_ADDRESS == ADDR_CTRL) begin
        logic [31:0] m;
        m = CTRL_WR_MASK & be_mask;
        // personality frozen while either engine runs
        if (locked || SPI_ENABLE) begin
          m[CTL_PERS_BIT] = 1'b0; // RQ1
        end
        // config frozen while audio runs
        if (locked) begin
          m = m & ~CTRL_LOCK_MASK; // RQ3 RQ4 RQ5 RQ6
        end
        nxt_ctrl = (ctrl_ff & ~m) | (wr_val & m);
        // reserved sample width keeps the old value
        if (nxt_ctrl[CTL_DLEN_LO +: 2] == DLEN_RSVD) begin
          nxt_ctrl[CTL_DLEN_LO +: 2] = ctrl_ff[CTL_DLEN_LO +: 2]; // RQ7
        end
      end else if (AVS_ADDRESS == ADDR_PSC && !locked) begin
        logic [31:0] p;
        p = PSC_WR_MASK & be_mask;
        nxt_psc = (psc_ff & ~p) | (wr_val & p); // RQ9 RQ11
        // a zero factor would stop the divider; keep the old one
        if (nxt_psc[PSC_DIV_LO +: DIV_W] == '0) begin
          nxt_psc[PSC_DIV_LO +: DIV_W] = psc_ff[PSC_DIV_LO +: DIV_W]; // RQ11
        end
      end
    end
    if (req && AVS_READ) begin
      unique case (AVS_ADDRESS)
        ADDR_CTRL: nxt_rdata = ctrl_ff;
        ADDR_PSC:  nxt_rdata = psc_ff;
        default:   nxt_rdata = UNMAPPED_VALUE;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_ff  <= CTRL_RESET; // RQ12
      psc_ff   <= PSC_RESET;  // RQ12
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      psc_ff   <= nxt_psc;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
    end
  end

  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = ~ack_ff;

  // ----------------------------------------------------------------
  // bit clock generation
  // ----------------------------------------------------------------
  logic [8:0] ratio;
  logic [8:0] cnt_ff, nxt_cnt;
  logic [8:0] high_len;
  logic       bclk_ff, nxt_bclk;
  logic       pin_d1_ff, pin_d2_ff, pin_d3_ff;
  logic       edge_ff, nxt_edge;
  logic       active;
  logic       master;

  // odd ratios give an idle-level phase one cycle shorter
  assign ratio    = {psc_ff[PSC_DIV_LO +: DIV_W], psc_ff[PSC_ODD_BIT]}; // RQ10
  assign high_len = ratio >> 1;
  assign active   = ctrl_ff[CTL_PERS_BIT] & ctrl_ff[CTL_EN_BIT]; // RQ2
  assign master   = ctrl_ff[CTL_ROLE_LO + 1];

  always_comb begin
    nxt_cnt  = '0;
    nxt_bclk = ctrl_ff[CTL_IDLE_CLOCK_POLARITY_BIT]; // RQ6
    nxt_edge = 1'b0;
    if (active && master) begin
      nxt_cnt  = (cnt_ff + 9'h001 >= ratio) ? 9'h000 : cnt_ff + 9'h001; // RQ13
      nxt_bclk = ctrl_ff[CTL_IDLE_CLOCK_POLARITY_BIT] ^ (nxt_cnt >= high_len);
      nxt_edge = (nxt_cnt == 9'h000);
    end else if (active) begin
      // slave: active edge is leaving idle level on the pin
      nxt_edge = (pin_d2_ff != ctrl_ff[CTL_IDLE_CLOCK_POLARITY_BIT]) &&
                 (pin_d3_ff == ctrl_ff[CTL_IDLE_CLOCK_POLARITY_BIT]); // RQ13
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_ff    <= '0;
      bclk_ff   <= 1'b0;
      edge_ff   <= 1'b0;
      pin_d1_ff <= 1'b0;
      pin_d2_ff <= 1'b0;
      pin_d3_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      bclk_ff   <= nxt_bclk;
      edge_ff   <= nxt_edge;
      pin_d1_ff <= SERIAL_BIT_CLOCK_PIN_IN;
      pin_d2_ff <= pin_d1_ff;
      pin_d3_ff <= pin_d2_ff;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic mck_ff, mckoe_n_ff, ckoe_n_ff, act_ff;
  ascp_cfg_t cfg_ff;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mck_ff     <= 1'b0;
      mckoe_n_ff <= 1'b1;
      ckoe_n_ff  <= 1'b1;
      act_ff     <= 1'b0;
      cfg_ff     <= '0;
    end else begin
      // master clock is the kernel clock halved, registered to keep outputs from flops
      mck_ff     <= active & psc_ff[PSC_MCKOE_BIT] & master & ~mck_ff;
      mckoe_n_ff <= ~(active & master & psc_ff[PSC_MCKOE_BIT]); // RQ9
      ckoe_n_ff  <= ~(active & master); // RQ13
      act_ff     <= active;
      // reserved bit 6 has no place in the carrier, so the fields are packed around it
      cfg_ff     <= {ctrl_ff[11:7], ctrl_ff[5:0]}; // RQ8
    end
  end

  assign SERIAL_BIT_CLOCK_PIN_OUT  = bclk_ff;
  assign SERIAL_BIT_CLOCK_PIN_OE_N = ckoe_n_ff;
  assign MASTER_CLOCK_PIN          = mck_ff;
  assign MASTER_CLOCK_PIN_OE_N     = mckoe_n_ff;
  assign AUDIO_ACTIVE              = act_ff;
  assign BIT_CLOCK_EDGE            = edge_ff;
  assign AUDIO_CFG                 = cfg_ff;
endmodule // ascp_top

// ===== ascp_top_monitor.sv
// checker for the ports of the audio config and prescaler block
// assumes one clock domain and a bind onto every ascp_top
`timescale 1ns/1ps
module ascp_top_monitor
  import ascp_pkg::*;
(
  input wire logic                MCLK,
  input wire logic                SYS_RST,
  input wire logic                AVS_READ,
  input wire logic                AVS_WRITE,
  input wire logic                AVS_WAITREQUEST,
  input wire logic                SPI_ENABLE,
  input wire logic                SERIAL_BIT_CLOCK_PIN_OUT,
  input wire logic                SERIAL_BIT_CLOCK_PIN_OE_N,
  input wire logic                MASTER_CLOCK_PIN_OE_N,
  input wire logic                AUDIO_ACTIVE,
  input wire logic                BIT_CLOCK_EDGE,
  input wire ascp_pkg::ascp_cfg_t AUDIO_CFG
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered");
  a_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer held too long");
  a_pers_lock: assert property ($changed(AUDIO_CFG.personality_select) |->
    !$past(SPI_ENABLE, 2) && !$past(AUDIO_ACTIVE, 2)) else $error("personality changed while locked");
  a_active_pair: assert property (AUDIO_ACTIVE == (AUDIO_CFG.personality_select
    && AUDIO_CFG.audio_enable)) else $error("active flag wrong");
  a_cfg_frozen: assert property (AUDIO_ACTIVE |=> $stable(AUDIO_CFG[8:0]))
    else $error("config changed while active");
  a_width_legal: assert property (AUDIO_CFG.sample_width_select != DLEN_RSVD)
    else $error("reserved sample width");
  a_idle_level: assert property ((!AUDIO_ACTIVE && $stable(AUDIO_CFG))[*3] |->
    SERIAL_BIT_CLOCK_PIN_OUT == AUDIO_CFG.idle_clock_polarity) else $error("idle level");
  a_bclk_drive: assert property (!SERIAL_BIT_CLOCK_PIN_OE_N |-> AUDIO_ACTIVE &&
    AUDIO_CFG.audio_role_select[1]) else $error("bit clock driven in slave role");
  a_mck_drive: assert property (!MASTER_CLOCK_PIN_OE_N |-> AUDIO_ACTIVE &&
    AUDIO_CFG.audio_role_select[1]) else $error("master clock driven wrongly");
  a_edge_pulse: assert property (BIT_CLOCK_EDGE |=> !BIT_CLOCK_EDGE)
    else $error("edge pulse too long");
  c_master: cover property (!SERIAL_BIT_CLOCK_PIN_OE_N && BIT_CLOCK_EDGE);
  c_slave: cover property (AUDIO_ACTIVE && SERIAL_BIT_CLOCK_PIN_OE_N && BIT_CLOCK_EDGE);
  c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule // ascp_top_monitor
bind ascp_top ascp_top_monitor mon (.MCLK(MCLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SPI_ENABLE(SPI_ENABLE),
  .SERIAL_BIT_CLOCK_PIN_OUT(SERIAL_BIT_CLOCK_PIN_OUT), .AUDIO_ACTIVE(AUDIO_ACTIVE),
  .SERIAL_BIT_CLOCK_PIN_OE_N(SERIAL_BIT_CLOCK_PIN_OE_N), .BIT_CLOCK_EDGE(BIT_CLOCK_EDGE),
  .MASTER_CLOCK_PIN_OE_N(MASTER_CLOCK_PIN_OE_N), .AUDIO_CFG(AUDIO_CFG));

// ===== ascp_codec_model.sv
// codec model that drives the serial bit clock in slave roles
// assumes the bench runs it only while the block is a slave
`timescale 1ns/1ps
module ascp_codec_model #(
  parameter int HALF_NS = 37
) (
  input  wire logic run,
  input  wire logic idle,
  output logic      bclk
);
  // unrelated to the kernel clock; stands at idle between frames
  initial bclk = 1'b0;
  always begin
    #(HALF_NS);
    bclk = run ? ~bclk : idle;
  end
endmodule // ascp_codec_model

// ===== i2s_mode_config_prescaler_tb.sv
// self-checking bench for the audio config and prescaler block
// assumes ascp_top, its monitor and the codec model compiled first
`timescale 1ns/1ps
module i2s_mode_config_prescaler_tb;
  import ascp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, spi_en = 1'b0, run = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, q, rdata, v, p;
  logic        cbclk, bclk, bc_out, bc_oe_n, mck, mck_oe_n, act, edge_p, wq;
  ascp_cfg_t   cfg;
  int          bad_count = 0, compares = 0, cyc = 0, n, d, o;
  always #5 clk = ~clk;
  assign bclk = bc_oe_n ? cbclk : bc_out;
  ascp_codec_model codec (.run(run), .idle(cfg.idle_clock_polarity), .bclk(cbclk));
  ascp_top dut (.MCLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_BYTEENABLE(4'hf), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .SPI_ENABLE(spi_en), .SERIAL_BIT_CLOCK_PIN_IN(bclk), .SERIAL_BIT_CLOCK_PIN_OUT(bc_out),
    .SERIAL_BIT_CLOCK_PIN_OE_N(bc_oe_n), .MASTER_CLOCK_PIN(mck), .AUDIO_CFG(cfg),
    .MASTER_CLOCK_PIN_OE_N(mck_oe_n), .AUDIO_ACTIVE(act), .BIT_CLOCK_EDGE(edge_p));
  function automatic logic [31:0] cfg_of(input logic [31:0] x);
    return {21'h0, x[11:7], x[5:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    int k;
    k = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= x;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 100);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(33271));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(0, ADDR_CTRL, 0);
    chk(q, CTRL_RESET);
    bus(0, ADDR_PSC, 0);
    chk(q, PSC_RESET);
    bus(1, 8'h24, 32'hffff_ffff);
    bus(0, 8'h24, 0);
    chk(q, UNMAPPED_VALUE);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      // every role, standard and width; slot never narrower than sample
      v = ($urandom & 32'h88) | (i % 4) << 8 | (i % 4) << 4 | (i % 3) << 1 | (i % 3 != 0);
      bus(1, ADDR_CTRL, v | 32'hffff_f040);
      bus(0, ADDR_CTRL, 0);
      chk(q, v);
      chk(32'(cfg), cfg_of(v));
      chk(32'(bc_out), 32'(v[3]));
      bus(1, ADDR_CTRL, v | 32'h6);
      bus(0, ADDR_CTRL, 0);
      chk(q, v);
    end
    $display("test config done");
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 1 : 1 + $urandom % 4;
      o = (i == 0) ? 1 : $urandom % 2;
      p = d | o << 8 | 1 << 9;
      bus(1, ADDR_PSC, p);
      bus(1, ADDR_PSC, p & 32'h300);
      bus(0, ADDR_PSC, 0);
      chk(q, p);
      v = 32'hc00 | (2 + i % 2) << 8 | i << 3;
      bus(1, ADDR_CTRL, v);
      bus(0, ADDR_CTRL, 0);
      chk(32'(act), 1);
      chk(32'(mck_oe_n), 0);
      chk(32'(bc_oe_n), 0);
      n = 0;
      while (edge_p !== 1'b1 && n < 600) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      n = 1;
      while (edge_p !== 1'b1 && n < 600) begin
        @(posedge clk);
        n++;
      end
      chk(n, 2 * d + o);
      n = mck;
      @(posedge clk);
      chk(32'(mck) ^ n, 1);
      bus(1, ADDR_PSC, 32'h5);
      bus(0, ADDR_PSC, 0);
      chk(q, p);
      bus(1, ADDR_CTRL, v ^ 32'h3bf);
      bus(0, ADDR_CTRL, 0);
      chk(q, v);
      bus(1, ADDR_CTRL, v & 32'hbff);
    end
    $display("test master done");
    spi_en <= 1'b1;
    bus(1, ADDR_CTRL, 32'h0);
    bus(0, ADDR_CTRL, 0);
    chk(32'(q[11]), 1);
    spi_en <= 1'b0;
    bus(1, ADDR_CTRL, 32'h400);
    repeat (3) @(posedge clk);
    chk(32'(act), 0);
    bus(1, ADDR_CTRL, 32'hc00 | ROLE_SLV_RX << 8);
    run <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (edge_p === 1'b1)
        n++;
    end
    chk(32'(n > 35 && n < 46), 1);
    chk(32'(bc_oe_n), 1);
    run <= 1'b0;
    $display("test slave done");
    finish_test();
  end
endmodule // i2s_mode_config_prescaler_tb
